// ==== rtl/ddrsr_bus_cycle.sv ====
// Bus-cycle logic of a burst-of-two double-data-rate common-I/O memory
//
// How it works
// - Write: address at K, beats K(t+1), K#(t+1)
// - Read: beats at C#(t+1) then C(t+2)
// - Writes on K/K# rises, reads on C/C#
// - Both C high: reads use K/K#
// - Control sampled at K; NOP keeps bus high-Z
// - Data outputs high impedance from power-up
// - Second beat uses next internal burst address
// - Second beat address has burst_lsb inverted
// - Cycle ends after two beats
// - Write state advances only on K-derived timing
// - Stopped clocks keep previous state
// - x8: two nibble masks, per beat
// - x9: one byte mask, per beat
// - x18: two byte masks, per beat
// - x36: four byte masks, per beat
// - Echo strobes toggle even when bus idle
`timescale 1ns/100ps
`default_nettype none
module ddrsr_bus_cycle
    import ddrsr_pkg::*;
#(
    parameter int FIFO_DEPTH = DDRSR_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    // Link clocks, sampled on ref_clk
    input  wire logic                    write_strobe_true,
    input  wire logic                    write_strobe_comp,
    input  wire logic                    output_phase_true,
    input  wire logic                    output_phase_comp,
    // Command and address
    input  wire logic                    cycle_request_n,
    input  wire logic                    read_not_write,
    input  wire logic [DDRSR_ADDR_W-1:0] address,
    // Data bus and lane masks (nibble_write_mask in x8)
    input  wire logic [DDRSR_DATA_W-1:0] dq_in,
    input  wire logic [DDRSR_LANES-1:0]  byte_write_mask,
    output logic [DDRSR_DATA_W-1:0]      dq_out,
    output logic                         dq_oe,
    // Echo strobes and write path status
    output logic                         echo_strobe,
    output logic                         echo_strobe_n,
    output logic                         write_ready
);
    localparam int AW = DDRSR_ADDR_W;

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    ddrsr_clks_t clks;
    ddrsr_clks_t clks_q;
    logic        k_rise;
    logic        kc_rise;
    logic        single_mode;
    logic        o_true_rise;
    logic        o_comp_rise;
    logic        cmd_wr;
    logic        cmd_rd;

    assign clks        = '{k: write_strobe_true, kc: write_strobe_comp,
                           c: output_phase_true, cc: output_phase_comp};
    assign k_rise      = clks.k & ~clks_q.k;
    assign kc_rise     = clks.kc & ~clks_q.kc;
    assign single_mode = clks.c & clks.cc;
    assign o_true_rise = single_mode ? k_rise : (clks.c & ~clks_q.c);
    assign o_comp_rise = single_mode ? kc_rise : (clks.cc & ~clks_q.cc);
    assign cmd_wr      = k_rise & ~cycle_request_n & ~read_not_write;
    assign cmd_rd      = k_rise & ~cycle_request_n & read_not_write;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clks_q <= '0;
        end
        else
        begin
            clks_q <= clks;
        end
    end

    // ------------------------------------------------------------
    // Write bus-cycle state machine
    // ------------------------------------------------------------
    ddrsr_wstate_t wstate_q;
    ddrsr_wstate_t wstate_d;
    logic [AW-1:0] wa_q;
    logic [AW-1:0] wa_d;
    logic          wn_v_q;
    logic          wn_v_d;
    logic [AW-1:0] wn_a_q;
    logic [AW-1:0] wn_a_d;
    logic          fifo_push;
    ddrsr_beat_t   push_beat;
    logic          fifo_in_ready;

    always_comb
    begin
        wstate_d  = wstate_q;
        wa_d      = wa_q;
        wn_v_d    = wn_v_q;
        wn_a_d    = wn_a_q;
        fifo_push = 1'b0;
        push_beat = '{addr: wa_q, data: dq_in, mask_n: byte_write_mask};
        unique case (wstate_q)
            W_IDLE:
            begin
                if (cmd_wr)
                begin
                    wa_d     = address;
                    wstate_d = W_BEAT1;
                end
            end
            W_BEAT1:
            begin
                if (k_rise)
                begin
                    fifo_push = 1'b1;
                    wstate_d  = W_BEAT2;
                    if (cmd_wr)
                    begin
                        wn_v_d = 1'b1;
                        wn_a_d = address;
                    end
                end
            end
            W_BEAT2:
            begin
                if (kc_rise)
                begin
                    fifo_push      = 1'b1;
                    push_beat.addr = {wa_q[AW-1:1], ~wa_q[0]};
                    wn_v_d         = 1'b0;
                    if (wn_v_q)
                    begin
                        wa_d     = wn_a_q;
                        wstate_d = W_BEAT1;
                    end
                    else
                    begin
                        wstate_d = W_IDLE;
                    end
                end
            end
        endcase
    end

    // Nothing moves without a strobe edge, so a stopped clock holds state
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wstate_q <= W_IDLE;
            wa_q     <= '0;
            wn_v_q   <= 1'b0;
            wn_a_q   <= '0;
        end
        else
        begin
            wstate_q <= wstate_d;
            wa_q     <= wa_d;
            wn_v_q   <= wn_v_d;
            wn_a_q   <= wn_a_d;
        end
    end

    // ------------------------------------------------------------
    // Write FIFO and masked array write
    // ------------------------------------------------------------
    logic                    fifo_out_valid;
    logic                    fifo_out_ready;
    logic [DDRSR_BEAT_W-1:0] fifo_out_data;
    ddrsr_beat_t             drain_beat;
    logic                    launch;

    logic [DDRSR_DATA_W-1:0] mem [2**AW];

    assign drain_beat     = ddrsr_beat_t'(fifo_out_data);
    assign fifo_out_ready = ~launch;

    ddrsr_fifo #(
        .WIDTH (DDRSR_BEAT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_beat),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Each active-low mask bit guards one lane of the beat
    always_ff @(posedge ref_clk)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            for (int i = 0; i < DDRSR_LANES; i++)
            begin
                if (!drain_beat.mask_n[i])
                begin
                    mem[drain_beat.addr][i*DDRSR_LANE_W +: DDRSR_LANE_W] <=
                        drain_beat.data[i*DDRSR_LANE_W +: DDRSR_LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read pipeline and output drive
    // ------------------------------------------------------------
    logic                    slot_v_q;
    logic                    slot_v_d;
    logic [AW-1:0]           slot_a_q;
    logic [AW-1:0]           slot_a_d;
    logic                    act_v_q;
    logic                    act_v_d;
    logic [AW-1:0]           act_a_q;
    logic [AW-1:0]           act_a_d;
    logic                    b2_v_q;
    logic                    b2_v_d;
    logic [AW-1:0]           b2_a_q;
    logic [AW-1:0]           b2_a_d;
    logic [DDRSR_DATA_W-1:0] dq_out_q;
    logic [DDRSR_DATA_W-1:0] dq_out_d;
    logic                    dq_oe_q;
    logic                    dq_oe_d;
    logic                    echo_q;
    logic                    echo_d;
    logic                    echo_n_q;
    logic                    wr_ready_q;

    always_comb
    begin
        slot_v_d = slot_v_q;
        slot_a_d = slot_a_q;
        act_v_d  = act_v_q;
        act_a_d  = act_a_q;
        b2_v_d   = b2_v_q;
        b2_a_d   = b2_a_q;
        dq_out_d = dq_out_q;
        dq_oe_d  = dq_oe_q;
        echo_d   = echo_q;
        launch   = 1'b0;
        if (o_comp_rise)
        begin
            echo_d  = 1'b0;
            dq_oe_d = act_v_q;
            if (act_v_q)
            begin
                launch   = 1'b1;
                dq_out_d = mem[act_a_q];
                act_v_d  = 1'b0;
                b2_v_d   = 1'b1;
                b2_a_d   = {act_a_q[AW-1:1], ~act_a_q[0]};
            end
        end
        else if (o_true_rise)
        begin
            echo_d  = 1'b1;
            dq_oe_d = b2_v_q;
            if (b2_v_q)
            begin
                launch   = 1'b1;
                dq_out_d = mem[b2_a_q];
                b2_v_d   = 1'b0;
            end
        end
        if (k_rise)
        begin
            slot_v_d = cmd_rd;
            slot_a_d = address;
            act_v_d  = slot_v_q;
            act_a_d  = slot_a_q;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slot_v_q   <= 1'b0;
            slot_a_q   <= '0;
            act_v_q    <= 1'b0;
            act_a_q    <= '0;
            b2_v_q     <= 1'b0;
            b2_a_q     <= '0;
            dq_out_q   <= '0;
            dq_oe_q    <= DDRSR_OE_RST;
            echo_q     <= DDRSR_ECHO_RST;
            echo_n_q   <= ~DDRSR_ECHO_RST;
            wr_ready_q <= DDRSR_READY_RST;
        end
        else
        begin
            slot_v_q   <= slot_v_d;
            slot_a_q   <= slot_a_d;
            act_v_q    <= act_v_d;
            act_a_q    <= act_a_d;
            b2_v_q     <= b2_v_d;
            b2_a_q     <= b2_a_d;
            dq_out_q   <= dq_out_d;
            dq_oe_q    <= dq_oe_d;
            echo_q     <= echo_d;
            echo_n_q   <= ~echo_d;
            wr_ready_q <= fifo_in_ready;
        end
    end

    assign dq_out        = dq_out_q;
    assign dq_oe         = dq_oe_q;
    assign echo_strobe   = echo_q;
    assign echo_strobe_n = echo_n_q;
    assign write_ready   = wr_ready_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_wr_cmd;
        cmd_wr && (wstate_q == W_IDLE);
    endsequence

    sequence s_wr_armed;
        (wstate_q == W_BEAT1) && (wa_q == $past(address));
    endsequence

    property p_wr_load;
        s_wr_cmd |=> s_wr_armed;
    endproperty
    a_wr_load: assert property (p_wr_load) else $error("write address not loaded");

    property p_nop_idle;
        k_rise && cycle_request_n && (wstate_q == W_IDLE) |=> (wstate_q == W_IDLE);
    endproperty
    a_nop_idle: assert property (p_nop_idle) else $error("no-operation started a cycle");

    property p_beat1_push;
        (wstate_q == W_BEAT1) && k_rise |-> fifo_push && (push_beat.addr == wa_q);
    endproperty
    a_beat1_push: assert property (p_beat1_push) else $error("first beat wrong");

    property p_beat2_addr;
        (wstate_q == W_BEAT2) && kc_rise |-> fifo_push && (push_beat.addr[0] != wa_q[0]);
    endproperty
    a_beat2_addr: assert property (p_beat2_addr) else $error("second beat lsb not inverted");

    property p_burst_end;
        (wstate_q == W_BEAT2) && kc_rise && !wn_v_q |=> (wstate_q == W_IDLE);
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("cycle did not end after two beats");

    property p_k_only;
        !k_rise && !kc_rise |=> $stable(wstate_q);
    endproperty
    a_k_only: assert property (p_k_only) else $error("state moved without strobe edge");

    sequence s_rd_pending;
        o_comp_rise && act_v_q;
    endsequence

    property p_rd_beats;
        s_rd_pending |=> dq_oe && b2_v_q;
    endproperty
    a_rd_beats: assert property (p_rd_beats) else $error("read beat not driven");

    property p_hiz_idle;
        o_comp_rise && !act_v_q |=> !dq_oe;
    endproperty
    a_hiz_idle: assert property (p_hiz_idle) else $error("bus driven without read");

    property p_echo;
        o_true_rise && !o_comp_rise |=> echo_strobe && !echo_strobe_n;
    endproperty
    a_echo: assert property (p_echo) else $error("echo strobe did not follow");

    property p_single;
        single_mode && k_rise && b2_v_q && !kc_rise |=> dq_oe && !b2_v_q;
    endproperty
    a_single: assert property (p_single) else $error("single clock read beat missing");

endmodule
`default_nettype wire

// ==== rtl/ddrsr_pkg.sv ====
// Shared constants and types for the burst-of-two memory bus-cycle block
package ddrsr_pkg;

    // ------------------------------------------------------------
    // Organisation: data width, write lanes, address
    // ------------------------------------------------------------
    // x36: 36/9/4, x18: 18/9/2, x9: 9/9/1, x8: 8/4/2 (nibble lanes)
    localparam int DDRSR_DATA_W     = 36;
    localparam int DDRSR_LANE_W     = 9;
    localparam int DDRSR_LANES      = 4;
    localparam int DDRSR_ADDR_W     = 10;
    localparam int DDRSR_FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Burst and reset values
    // ------------------------------------------------------------
    localparam int   DDRSR_BURST_LEN = 2;
    localparam logic DDRSR_OE_RST    = 1'b0;
    localparam logic DDRSR_ECHO_RST  = 1'b0;
    localparam logic DDRSR_READY_RST = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DDRSR_ADDR_W-1:0] addr;
        logic [DDRSR_DATA_W-1:0] data;
        logic [DDRSR_LANES-1:0]  mask_n;
    } ddrsr_beat_t;

    localparam int DDRSR_BEAT_W = $bits(ddrsr_beat_t);

    typedef struct packed {
        logic k;
        logic kc;
        logic c;
        logic cc;
    } ddrsr_clks_t;

    typedef enum logic [1:0] {
        W_IDLE,
        W_BEAT1,
        W_BEAT2
    } ddrsr_wstate_t;

endpackage

// ==== rtl/ddrsr_fifo.sv ====
// Write-beat FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ddrsr_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    wr_ptr_d;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    rd_ptr_d;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             push;
    logic             pop;

    assign in_ready  = (count_q != FULL_CNT);
    assign out_valid = (count_q != '0);
    assign out_data  = store[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ------------------------------------------------------------
    // Pointer and count update
    // ------------------------------------------------------------
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (push)
        begin
            wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
        end
        if (push && !pop)
        begin
            count_d = count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            store[wr_ptr_q] <= in_data;
        end
    end

endmodule
`default_nettype wire

// ==== tb/ddrsr_ctrl_model.sv ====
// Memory controller model: strobes, output phases, commands and write beats
`timescale 1ns/100ps
`default_nettype none
module ddrsr_ctrl_model
    import ddrsr_pkg::*;
(
    // Clock
    input  wire logic                    ref_clk,
    // Strobes and output phases
    output logic                         k,
    output logic                         kc,
    output logic                         c,
    output logic                         cc,
    // Command
    output logic                         req_n,
    output logic                         rnw,
    output logic [DDRSR_ADDR_W-1:0]      addr,
    // Write beats
    output logic [DDRSR_DATA_W-1:0]      dq,
    output logic [DDRSR_LANES-1:0]       mask_n
);
    logic [DDRSR_DATA_W-1:0] pd1;
    logic [DDRSR_DATA_W-1:0] pd2;
    logic [DDRSR_LANES-1:0]  pm1;
    logic [DDRSR_LANES-1:0]  pm2;

    initial
    begin
        {k, kc, c, cc, req_n, rnw, addr, dq, mask_n} = '0;
        {pd1, pd2, pm1, pm2} = '0;
    end

    // Lines change once their sampling edge has passed
    task automatic noise();
        req_n  = 1'($urandom);
        rnw    = 1'($urandom);
        addr   = DDRSR_ADDR_W'($urandom);
        dq     = DDRSR_DATA_W'({$urandom, $urandom});
        mask_n = DDRSR_LANES'($urandom);
    endtask

    // One strobe period of 8 cycles, each level 4 cycles
    task automatic kperiod(input logic rq, input logic rw, input logic [DDRSR_ADDR_W-1:0] a,
                           input logic [DDRSR_DATA_W-1:0] d1, input logic [DDRSR_LANES-1:0] m1,
                           input logic [DDRSR_DATA_W-1:0] d2, input logic [DDRSR_LANES-1:0] m2,
                           input logic single);
        @(negedge ref_clk);
        {k, kc, c, cc} = {3'b101, single};
        {req_n, rnw, addr, dq, mask_n} = {rq, rw, a, pd1, pm1};
        @(negedge ref_clk);
        noise();
        repeat (2) @(negedge ref_clk);
        @(negedge ref_clk);
        {k, kc, c, cc} = {2'b01, single, 1'b1};
        {dq, mask_n} = {pd2, pm2};
        @(negedge ref_clk);
        noise();
        repeat (2) @(negedge ref_clk);
        {pd1, pd2, pm1, pm2} = {d1, d2, m1, m2};
    endtask

    // Clock stop with all four parked at one level
    task automatic pause(input int n);
        @(negedge ref_clk);
        {k, kc, c, cc} = 4'h0;
        repeat (n - 1) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the burst-of-two bus-cycle block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ddrsr_pkg::*;
();
    localparam int D = DDRSR_DATA_W;
    localparam int A = DDRSR_ADDR_W;
    localparam int L = DDRSR_LANES;
    localparam int W = DDRSR_LANE_W;

    logic ref_clk, arst_n, k, kc, c, cc, req_n, rnw, dq_oe, echo, echo_n, wready, single;
    logic [A-1:0] addr;
    logic [A-1:0] av [4];
    logic [D-1:0] cdq, dq_in, dq_out;
    logic [L-1:0] mask_n;
    logic [D-1:0] mem [0:(1<<A)-1];
    logic [D-1:0] expq [$];
    int num_errors, checks_done, cycles, dual_run;
    logic pt, pc, last_single;
    logic [1:0] ev, evn;

    // Bus level from both drivers
    assign dq_in = dq_oe ? dq_out : cdq;

    ddrsr_ctrl_model ddrsr_ctrl_model_inst (.ref_clk(ref_clk), .k(k), .kc(kc), .c(c), .cc(cc), .req_n(req_n),
        .rnw(rnw), .addr(addr), .dq(cdq), .mask_n(mask_n));

    ddrsr_bus_cycle #(.FIFO_DEPTH(DDRSR_FIFO_DEPTH)) ddrsr_bus_cycle_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .write_strobe_true(k), .write_strobe_comp(kc), .output_phase_true(c), .output_phase_comp(cc),
        .cycle_request_n(req_n), .read_not_write(rnw), .address(addr), .dq_in(dq_in),
        .byte_write_mask(mask_n), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe(echo),
        .echo_strobe_n(echo_n), .write_ready(wready));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic cmp_data(input string what, input logic [D-1:0] exp, input logic [D-1:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [D-1:0] rnd();
        return D'({$urandom, $urandom});
    endfunction

    task automatic wr(input logic [A-1:0] a, input logic [L-1:0] m1, input logic [L-1:0] m2);
        logic [D-1:0] d1;
        logic [D-1:0] d2;
        d1 = rnd();
        d2 = rnd();
        for (int i = 0; i < L; i++)
        begin
            if (!m1[i]) mem[a][i*W +: W] = d1[i*W +: W];
            if (!m2[i]) mem[a ^ A'(1)][i*W +: W] = d2[i*W +: W];
        end
        ddrsr_ctrl_model_inst.kperiod(1'b0, 1'b0, a, d1, m1, d2, m2, single);
    endtask

    task automatic rd(input logic [A-1:0] a);
        expq.push_back(mem[a]);
        expq.push_back(mem[a ^ A'(1)]);
        ddrsr_ctrl_model_inst.kperiod(1'b0, 1'b1, a, rnd(), L'($urandom), rnd(), L'($urandom), single);
    endtask

    task automatic nop(input int n);
        repeat (n) ddrsr_ctrl_model_inst.kperiod(1'b1, 1'($urandom), A'($urandom), rnd(), L'($urandom),
                                                 rnd(), L'($urandom), single);
    endtask

    // Output watcher: one result after each output-phase rise
    initial
    begin
        {pt, pc, last_single, ev, dual_run} = '0;
    end

    always @(posedge ref_clk)
    begin
        evn = 2'd0;
        if (((c & cc) ? k : c) && !pt) evn = 2'd1;
        if (((c & cc) ? kc : cc) && !pc) evn = 2'd2;
        pt = (c & cc) ? k : c;
        pc = (c & cc) ? kc : cc;
        dual_run = ((c & cc) != last_single) ? 0 : dual_run + 1;
        last_single = c & cc;
        if (ev != 2'd0)
        begin
            #1;
            if (dual_run >= 3)
            begin
                cmp_flag("echo_strobe", ev == 2'd1, echo);
                cmp_flag("echo_strobe_n", ev != 2'd1, echo_n);
            end
            if (dq_oe === 1'b1 && expq.size() == 0)
                cmp_flag("dq_oe", 1'b0, dq_oe);
            else if (dq_oe === 1'b1)
                cmp_data("dq_out", expq.pop_front(), dq_out);
            else
                cmp_flag("dq_oe_known", 1'b0, dq_oe);
        end
        ev = evn;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        {arst_n, single, num_errors, checks_done, cycles} = '0;
        void'($urandom(32'hA58A7B88));
        repeat (3) @(negedge ref_clk);
        cmp_flag("dq_oe", 1'b0, dq_oe);
        cmp_flag("echo_strobe_n", 1'b1, echo_n);
        cmp_flag("write_ready", 1'b1, wready);
        arst_n = 1'b1;
        nop(2);
        cmp_flag("dq_oe", 1'b0, dq_oe);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            av[i] = A'($urandom);
            wr(av[i], 4'h0, 4'h0);
        end
        for (int i = 0; i < 4; i++) rd(av[i]);
        nop(2);
        $display("test burst done");
        for (int i = 0; i < 4; i++) wr(av[i], L'($urandom), L'($urandom));
        for (int i = 0; i < 4; i++) rd(av[i]);
        nop(2);
        $display("test mask done");
        single = 1'b1;
        nop(2);
        rd(av[0]);
        rd(av[3]);
        nop(2);
        single = 1'b0;
        nop(2);
        $display("test single clock done");
        rd(av[1]);
        ddrsr_ctrl_model_inst.pause(20);
        nop(3);
        $display("test clock stop done");
        cmp_flag("write_ready", 1'b1, wready);
        cmp_data("pending_beats", D'(0), D'(expq.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire
